// [rtl/adcrc_pkg.sv]
// Constants, field layouts and state type of the converter result and clock control block.
package adcrc_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] ADCRC_OFS_RESULT_HIGH = 8'h3D;
   localparam logic [7:0] ADCRC_OFS_RESULT_LOW  = 8'h3E;
   localparam logic [7:0] ADCRC_OFS_CLOCK_CTRL  = 8'h3F;
   localparam logic [7:0] ADCRC_OFS_IRQ_STATUS  = 8'h40;
   localparam logic [7:0] ADCRC_OFS_IRQ_MASK    = 8'h41;

   // Field positions inside the converter clock control register.
   localparam int ADCRC_PRESCALE_MSB  = 7;
   localparam int ADCRC_PRESCALE_LSB  = 5;
   localparam int ADCRC_CLKSEL_BIT    = 4;
   localparam int ADCRC_JUSTIFY_HI    = 3;
   localparam int ADCRC_JUSTIFY_LO    = 2;

   // Interrupt status and mask bit positions.
   localparam int ADCRC_EVT_DONE      = 0;
   localparam int ADCRC_EVT_LOST      = 1;
   localparam int ADCRC_EVT_COUNT     = 2;

   // Justification modes.
   localparam logic [1:0] ADCRC_MODE_TRUNC = 2'h0;
   localparam logic [1:0] ADCRC_MODE_RIGHT = 2'h1;
   localparam logic [1:0] ADCRC_MODE_LEFT  = 2'h2;
   localparam logic [1:0] ADCRC_MODE_SIGN  = 2'h3;

   // Values after reset.
   localparam logic [2:0] ADCRC_PRESCALE_RESET = 3'h0;
   localparam logic       ADCRC_CLKSEL_RESET   = 1'b0;
   localparam logic [1:0] ADCRC_MODE_RESET     = ADCRC_MODE_RIGHT;
   localparam logic [9:0] ADCRC_RESULT_RESET   = 10'h000;
   localparam logic [3:0] ADCRC_DIV_RESET      = 4'h0;

   // Whole state of the block, registered in one process.
   typedef struct packed {
      logic [9:0]                 res;
      logic                       lock;
      logic                       flag;
      logic [2:0]                 prescale;
      logic                       clk_sel;
      logic [1:0]                 mode;
      logic [ADCRC_EVT_COUNT-1:0] status;
      logic [ADCRC_EVT_COUNT-1:0] mask;
      logic [3:0]                 div_cnt;
      logic                       clk_en;
      logic [7:0]                 rd_data;
   } adcrc_state_t;

endpackage : adcrc_pkg

// [rtl/adcrc_top.sv]
// Result register pair, justification and converter clock divider of the 10-bit converter.
//
// Operation
// - Each 10-bit conversion result is shown through a high and a low 8-bit read register, placed by the justify mode.
// - In truncated mode the low byte shows result bits 9 to 2 and the high byte reads zero.
// - In truncated mode the low byte is refreshed at every completion and a high byte read locks nothing.
// - In right justified mode bits 9 and 8 sit in high byte bits 1 and 0 and bits 7 to 0 fill the low byte.
// - In left justified mode bits 9 to 2 fill the high byte and bits 1 and 0 sit in low byte bits 7 and 6.
// - In left justified sign mode the layout is left justified with the top result bit inverted.
// - In the 10-bit modes a high byte read freezes the pair and later results are dropped until the low byte is read.
// - In the 10-bit modes both bytes are updated at each completion unless the pair is frozen.
// - The 3-bit prescale field divides the source by 1, 2, 4, 8, or 16 when its top bit is set.
// - The input clock select bit picks the bus clock when 1 and the crystal clock when 0, crystal after reset.
// - The 2-bit justify field selects truncated, right, left or left sign format, right justified after reset.
// - Any write to the clock control register clears the conversion complete flag, except in a cycle with a completion.
// - A read of the low result byte clears the conversion complete flag, except in a cycle with a completion.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps

module adcrc_top
   import adcrc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       conv_done,
   input  wire logic [9:0] conv_result,
   input  wire logic       crystal_reference_clock,
   output logic            adc_clk_en,
   output logic            conversion_complete_flag,
   output logic            irq
);

   adcrc_state_t st;
   adcrc_state_t next_st;

   logic       rd_high;
   logic       rd_low;
   logic       rd_ctrl;
   logic       rd_stat;
   logic       rd_mask;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       wr_mask;
   logic       frozen;
   logic       src_tick;
   logic [3:0] div_mask;
   logic [7:0] ctrl_view;

   // High byte as seen by software for a given mode and stored result.
   function automatic logic [7:0] adcrc_high(input logic [1:0] mode, input logic [9:0] res);
      logic [7:0] v;
      v = 8'h00;
      case (mode)
         ADCRC_MODE_TRUNC : v = 8'h00;
         ADCRC_MODE_RIGHT : v = {6'h00, res[9:8]};
         ADCRC_MODE_LEFT  : v = res[9:2];
         default          : v = {~res[9], res[8:2]};
      endcase
      return v;
   endfunction : adcrc_high

   // Low byte as seen by software for a given mode and stored result.
   function automatic logic [7:0] adcrc_low(input logic [1:0] mode, input logic [9:0] res);
      logic [7:0] v;
      v = 8'h00;
      case (mode)
         ADCRC_MODE_TRUNC : v = res[9:2];
         ADCRC_MODE_RIGHT : v = res[7:0];
         default          : v = {res[1:0], 6'h00};
      endcase
      return v;
   endfunction : adcrc_low

   // Divider length as a mask of low counter bits.
   function automatic logic [3:0] adcrc_div_mask(input logic [2:0] prescale);
      logic [3:0] m;
      m = 4'h0;
      if (prescale[2]) begin
         m = 4'hF;
      end else if (prescale == 3'h3) begin
         m = 4'h7;
      end else if (prescale == 3'h2) begin
         m = 4'h3;
      end else if (prescale == 3'h1) begin
         m = 4'h1;
      end else begin
         m = 4'h0;
      end
      return m;
   endfunction : adcrc_div_mask

   // Address decoding of the register port.
   always_comb begin
      rd_high = 1'b0;
      rd_low  = 1'b0;
      rd_ctrl = 1'b0;
      rd_stat = 1'b0;
      rd_mask = 1'b0;
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (reg_addr == ADCRC_OFS_RESULT_HIGH) begin
         rd_high = reg_rd;
      end else if (reg_addr == ADCRC_OFS_RESULT_LOW) begin
         rd_low = reg_rd;
      end else if (reg_addr == ADCRC_OFS_CLOCK_CTRL) begin
         rd_ctrl = reg_rd;
         wr_ctrl = reg_wr;
      end else if (reg_addr == ADCRC_OFS_IRQ_STATUS) begin
         rd_stat = reg_rd;
         wr_stat = reg_wr;
      end else if (reg_addr == ADCRC_OFS_IRQ_MASK) begin
         rd_mask = reg_rd;
         wr_mask = reg_wr;
      end
   end

   assign src_tick = st.clk_sel ? 1'b1 : crystal_reference_clock;
   assign div_mask = adcrc_div_mask(st.prescale);

   // A high byte read in the same cycle as a completion already counts as frozen, so the
   // pair software is assembling never mixes two conversions.
   assign frozen = (st.mode != ADCRC_MODE_TRUNC) && (st.lock || rd_high);

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[ADCRC_PRESCALE_MSB:ADCRC_PRESCALE_LSB] = st.prescale;
      ctrl_view[ADCRC_CLKSEL_BIT] = st.clk_sel;
      ctrl_view[ADCRC_JUSTIFY_HI] = st.mode[1];
      ctrl_view[ADCRC_JUSTIFY_LO] = st.mode[0];
   end

   always_comb begin
      next_st = st;
      next_st.rd_data = 8'h00;

      // Result capture; bus writes to the result offsets fall through untouched.
      if (conv_done && !frozen) begin
         next_st.res = conv_result;
      end
      // A mode change keeps the lock; it has no effect in truncated mode, so software returning
      // to a 10-bit mode with a pending high byte read must still read the low byte to release it.
      if (rd_high && st.mode != ADCRC_MODE_TRUNC) begin
         next_st.lock = 1'b1;
      end else if (rd_low) begin
         next_st.lock = 1'b0;
      end

      // Conversion complete flag: a completion wins over a clear in the same cycle.
      if (conv_done) begin
         next_st.flag = 1'b1;
      end else if (wr_ctrl) begin
         next_st.flag = 1'b0;
      end else if (rd_low) begin
         next_st.flag = 1'b0;
      end

      if (wr_ctrl) begin
         next_st.prescale = reg_wdata[ADCRC_PRESCALE_MSB:ADCRC_PRESCALE_LSB];
         next_st.clk_sel  = reg_wdata[ADCRC_CLKSEL_BIT];
         next_st.mode     = {reg_wdata[ADCRC_JUSTIFY_HI], reg_wdata[ADCRC_JUSTIFY_LO]};
      end

      // Sticky events, cleared by writing one; a new event beats the clear.
      if (wr_stat) begin
         next_st.status = st.status & ~reg_wdata[ADCRC_EVT_COUNT-1:0];
      end
      if (conv_done) begin
         next_st.status[ADCRC_EVT_DONE] = 1'b1;
      end
      if (conv_done && frozen) begin
         next_st.status[ADCRC_EVT_LOST] = 1'b1;
      end
      if (wr_mask) begin
         next_st.mask = reg_wdata[ADCRC_EVT_COUNT-1:0];
      end

      // The counter runs freely on source ticks; changing the prescaler needs no restart.
      // The price is that the first strobe after a prescaler change may come early.
      next_st.clk_en = 1'b0;
      if (src_tick) begin
         next_st.div_cnt = st.div_cnt + 4'h1;
         next_st.clk_en  = ((st.div_cnt & div_mask) == div_mask);
      end

      if (rd_high) begin
         next_st.rd_data = adcrc_high(st.mode, st.res);
      end else if (rd_low) begin
         next_st.rd_data = adcrc_low(st.mode, st.res);
      end else if (rd_ctrl) begin
         next_st.rd_data = ctrl_view;
      end else if (rd_stat) begin
         next_st.rd_data = {6'h00, st.status};
      end else if (rd_mask) begin
         next_st.rd_data = {6'h00, st.mask};
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st.res      <= ADCRC_RESULT_RESET;
         st.lock     <= 1'b0;
         st.flag     <= 1'b0;
         st.prescale <= ADCRC_PRESCALE_RESET;
         st.clk_sel  <= ADCRC_CLKSEL_RESET;
         st.mode     <= ADCRC_MODE_RESET;
         st.status   <= '0;
         st.mask     <= '0;
         st.div_cnt  <= ADCRC_DIV_RESET;
         st.clk_en   <= 1'b0;
         st.rd_data  <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata                = st.rd_data;
   assign adc_clk_en               = st.clk_en;
   assign conversion_complete_flag = st.flag;
   assign irq                      = |(st.status & st.mask);

   // Checks on the register view, the result interlock, the complete flag, the reset values and the divider strobe.
   chk_trunc_high_zero : assert property (@(posedge mclk) disable iff (!resetn)
      rd_high && st.mode == ADCRC_MODE_TRUNC |=> reg_rdata == 8'h00)
      else $error("Truncated high byte not zero.");

   chk_trunc_low_bits : assert property (@(posedge mclk) disable iff (!resetn)
      rd_low && st.mode == ADCRC_MODE_TRUNC |=> reg_rdata == $past(st.res[9:2]))
      else $error("Truncated low byte wrong.");

   chk_trunc_no_lock : assert property (@(posedge mclk) disable iff (!resetn)
      st.mode == ADCRC_MODE_TRUNC && conv_done |=> st.res == $past(conv_result))
      else $error("Truncated mode missed an update.");

   chk_right_low_byte : assert property (@(posedge mclk) disable iff (!resetn)
      rd_low && st.mode == ADCRC_MODE_RIGHT |=> reg_rdata == $past(st.res[7:0]))
      else $error("Right justified low byte wrong.");

   chk_right_high_byte : assert property (@(posedge mclk) disable iff (!resetn)
      rd_high && st.mode == ADCRC_MODE_RIGHT |=> reg_rdata == {6'h00, $past(st.res[9:8])})
      else $error("Right justified high byte wrong.");

   chk_left_high_byte : assert property (@(posedge mclk) disable iff (!resetn)
      rd_high && st.mode == ADCRC_MODE_LEFT |=> reg_rdata == $past(st.res[9:2]))
      else $error("Left justified high byte wrong.");

   chk_left_low_byte : assert property (@(posedge mclk) disable iff (!resetn)
      rd_low && st.mode[1] |=> reg_rdata == {$past(st.res[1:0]), 6'h00})
      else $error("Left justified low byte wrong.");

   chk_sign_msb_inv : assert property (@(posedge mclk) disable iff (!resetn)
      rd_high && st.mode == ADCRC_MODE_SIGN |=> reg_rdata == {~$past(st.res[9]), $past(st.res[8:2])})
      else $error("Sign mode high byte wrong.");

   chk_frozen_pair : assert property (@(posedge mclk) disable iff (!resetn)
      st.mode != ADCRC_MODE_TRUNC ##0 rd_high ##1 (!rd_low && !wr_ctrl) [*2] |-> st.res == $past(st.res, 2))
      else $error("Frozen pair was overwritten.");

   chk_update_pair : assert property (@(posedge mclk) disable iff (!resetn)
      conv_done && !st.lock && !rd_high |=> st.res == $past(conv_result))
      else $error("Result pair not updated.");

   chk_div_two : assert property (@(posedge mclk) disable iff (!resetn)
      st.clk_sel && st.prescale == 3'h1 && !reg_wr ##1 adc_clk_en && !reg_wr |=> !adc_clk_en ##1 adc_clk_en)
      else $error("Divide by two strobe spacing wrong.");

   chk_reset_values : assert property (@(posedge mclk) disable iff (!resetn)
      $rose(resetn) |-> st.clk_sel == 1'b0 && st.mode == ADCRC_MODE_RIGHT)
      else $error("Reset clock source or mode wrong.");

   chk_ctrl_clears : assert property (@(posedge mclk) disable iff (!resetn)
      wr_ctrl && !conv_done |=> !conversion_complete_flag)
      else $error("Control write left flag set.");

   chk_low_clears : assert property (@(posedge mclk) disable iff (!resetn)
      rd_low && !conv_done |=> !conversion_complete_flag)
      else $error("Low byte read left flag set.");

   chk_result_wr_ign : assert property (@(posedge mclk) disable iff (!resetn)
      reg_wr && (reg_addr == ADCRC_OFS_RESULT_HIGH || reg_addr == ADCRC_OFS_RESULT_LOW) && !conv_done
      |=> st.res == $past(st.res) && st.lock == $past(st.lock))
      else $error("Result write disturbed state.");

   chk_trunc_high_free : assert property (@(posedge mclk) disable iff (!resetn)
      rd_high && st.mode == ADCRC_MODE_TRUNC |=> st.lock == $past(st.lock))
      else $error("Truncated high byte read changed the lock.");

   chk_lost_result : assert property (@(posedge mclk) disable iff (!resetn)
      conv_done && st.lock && st.mode != ADCRC_MODE_TRUNC |=> st.status[ADCRC_EVT_LOST] && st.res == $past(st.res))
      else $error("Completion while frozen was not dropped.");

   chk_strobe_single : assert property (@(posedge mclk) disable iff (!resetn)
      adc_clk_en && st.prescale != 3'h0 && $stable(st.prescale) |=> !adc_clk_en)
      else $error("Divided strobe longer than one cycle.");

endmodule : adcrc_top

// [verif/tb_adcrc_top.sv]
// Self-checking testbench of the converter result and clock control block.
`timescale 1ns/10ps

module tb_adcrc_top
   import adcrc_pkg::*;
;
   logic       mclk                     = 1'b0;
   logic       resetn                   = 1'b0;
   logic [7:0] reg_addr                 = 8'h00;
   logic [7:0] reg_wdata                = 8'h00;
   logic       reg_wr                   = 1'b0;
   logic       reg_rd                   = 1'b0;
   logic [7:0] reg_rdata;
   logic       conv_done                = 1'b0;
   logic [9:0] conv_result              = 10'h000;
   logic       crystal_reference_clock  = 1'b0;
   logic       adc_clk_en;
   logic       conversion_complete_flag;
   logic       irq;
   logic [1:0] xtal_cnt                 = 2'h0;
   int         fail_count               = 0;
   int         checks_done              = 0;

   adcrc_top dut (
      .mclk                     (mclk),
      .resetn                   (resetn),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_wr                   (reg_wr),
      .reg_rd                   (reg_rd),
      .reg_rdata                (reg_rdata),
      .conv_done                (conv_done),
      .conv_result              (conv_result),
      .crystal_reference_clock  (crystal_reference_clock),
      .adc_clk_en               (adc_clk_en),
      .conversion_complete_flag (conversion_complete_flag),
      .irq                      (irq)
   );

   always #12.5 mclk = ~mclk;

   // Crystal ticks every third bus cycle, so a divided count over whole windows is exact.
   always @(posedge mclk) begin
      xtal_cnt <= (xtal_cnt == 2'h2) ? 2'h0 : xtal_cnt + 2'h1;
      crystal_reference_clock <= (xtal_cnt == 2'h2);
   end

   task automatic report(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : report

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      report({8'h00, got}, {8'h00, exp});
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      report({15'h0000, got}, {15'h0000, exp});
   endtask : chk_bit

   task automatic chk_cnt(input int got, input int exp);
      report(got[15:0], exp[15:0]);
   endtask : chk_cnt

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(negedge mclk);
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk_byte(reg_rdata, exp);
   endtask : rd_chk

   task automatic conv(input logic [9:0] v);
      @(posedge mclk);
      conv_done   <= 1'b1;
      conv_result <= v;
      @(posedge mclk);
      conv_done <= 1'b0;
      @(negedge mclk);
   endtask : conv

   function automatic logic [7:0] ctrl(input logic [2:0] p, input logic s, input logic [1:0] m);
      return {p, s, m, 2'b00};
   endfunction : ctrl

   function automatic logic [7:0] fmt(input logic [1:0] m, input logic [9:0] r, input bit hi);
      case (m)
         ADCRC_MODE_TRUNC: return hi ? 8'h00 : r[9:2];
         ADCRC_MODE_RIGHT: return hi ? {6'h00, r[9:8]} : r[7:0];
         ADCRC_MODE_LEFT:  return hi ? r[9:2] : {r[1:0], 6'h00};
         default:          return hi ? {~r[9], r[8:2]} : {r[1:0], 6'h00};
      endcase
   endfunction : fmt

   task automatic t_reset();
      rd_chk(ADCRC_OFS_CLOCK_CTRL, 8'h04);
      rd_chk(ADCRC_OFS_RESULT_HIGH, 8'h00);
      rd_chk(ADCRC_OFS_RESULT_LOW, 8'h00);
      rd_chk(8'h55, 8'h00);
      chk_bit(conversion_complete_flag, 1'b0);
      chk_bit(irq, 1'b0);
   endtask : t_reset

   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, m[1:0]));
         rd_chk(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, m[1:0]));
         conv(10'h2B5);
         chk_bit(conversion_complete_flag, 1'b1);
         rd_chk(ADCRC_OFS_RESULT_HIGH, fmt(m[1:0], 10'h2B5, 1'b1));
         rd_chk(ADCRC_OFS_RESULT_LOW, fmt(m[1:0], 10'h2B5, 1'b0));
         chk_bit(conversion_complete_flag, 1'b0);
      end
   endtask : t_modes

   task automatic t_lock();
      wr(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, ADCRC_MODE_RIGHT));
      wr(ADCRC_OFS_IRQ_STATUS, 8'h03);
      conv(10'h155);
      rd_chk(ADCRC_OFS_RESULT_HIGH, 8'h01);
      conv(10'h2AA);
      rd_chk(ADCRC_OFS_RESULT_LOW, 8'h55);
      rd_chk(ADCRC_OFS_IRQ_STATUS, 8'h03);
      conv(10'h3C3);
      rd_chk(ADCRC_OFS_RESULT_HIGH, 8'h03);
      rd_chk(ADCRC_OFS_RESULT_LOW, 8'hC3);
      wr(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, ADCRC_MODE_TRUNC));
      conv(10'h155);
      rd_chk(ADCRC_OFS_RESULT_HIGH, 8'h00);
      conv(10'h2AA);
      rd_chk(ADCRC_OFS_RESULT_LOW, 8'hAA);
   endtask : t_lock

   task automatic t_flags();
      wr(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, ADCRC_MODE_RIGHT));
      conv(10'h1E7);
      wr(ADCRC_OFS_RESULT_HIGH, 8'hFF);
      wr(ADCRC_OFS_RESULT_LOW, 8'hFF);
      rd_chk(ADCRC_OFS_RESULT_HIGH, 8'h01);
      rd_chk(ADCRC_OFS_RESULT_LOW, 8'hE7);
      conv(10'h0F0);
      chk_bit(conversion_complete_flag, 1'b1);
      wr(ADCRC_OFS_CLOCK_CTRL, ctrl(3'h0, 1'b1, ADCRC_MODE_RIGHT));
      chk_bit(conversion_complete_flag, 1'b0);
   endtask : t_flags

   task automatic t_irq();
      wr(ADCRC_OFS_IRQ_STATUS, 8'h03);
      wr(ADCRC_OFS_IRQ_MASK, 8'h01);
      chk_bit(irq, 1'b0);
      conv(10'h011);
      chk_bit(irq, 1'b1);
      wr(ADCRC_OFS_IRQ_STATUS, 8'h01);
      chk_bit(irq, 1'b0);
      wr(ADCRC_OFS_IRQ_MASK, 8'h00);
      conv(10'h022);
      chk_bit(irq, 1'b0);
      rd_chk(ADCRC_OFS_IRQ_STATUS, 8'h01);
      rd_chk(ADCRC_OFS_IRQ_MASK, 8'h00);
   endtask : t_irq

   // Strobes are counted over whole divider periods after settling, since the first period may be short.
   task automatic count_en(input logic [7:0] c, input int win, input int exp);
      int n;
      n = 0;
      wr(ADCRC_OFS_CLOCK_CTRL, c);
      repeat (40) @(negedge mclk);
      for (int i = 0; i < win; i++) begin
         @(negedge mclk);
         if (adc_clk_en === 1'b1) n++;
      end
      chk_cnt(n, exp);
   endtask : count_en

   task automatic t_div();
      for (int p = 0; p < 8; p++) begin
         count_en(ctrl(p[2:0], 1'b1, ADCRC_MODE_RIGHT), 64, p[2] ? 4 : 64 >> p[1:0]);
      end
      count_en(ctrl(3'h1, 1'b0, ADCRC_MODE_RIGHT), 96, 16);
      // Crystal ticks at a third of the bus rate are fast enough to use, and divided by 16 land in range.
      count_en(ctrl(3'h4, 1'b0, ADCRC_MODE_RIGHT), 96, 2);
   endtask : t_div

   task automatic wrap_up();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #2500000;
      fail_count++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      t_reset();
      t_modes();
      t_lock();
      t_flags();
      t_irq();
      t_div();
      wrap_up();
   end
endmodule : tb_adcrc_top
